// ---- rtl/cch_pkg.sv ----
// shared constants and carrier types of the cascade port controller
package cch_pkg;
	// data widths of the device pins and of the phase timer
	localparam int AC_W     = 13;        // address/control bus width
	localparam int DATA_W   = 32;        // data bus width
	localparam int RES_W    = 16;        // bank id plus active index width
	localparam int TMR_W    = 4;         // width of the phase timer
	// clock and strobe timing
	localparam int CLK_NS      = 8;      // system clock period
	localparam int T_SETUP_NS  = 10;     // pins stable before strobe falls
	localparam int T_LOW_NS    = 40;     // strobe low time
	localparam int T_HIGH_NS   = 20;     // strobe high recovery time
	localparam int T_SETTLE_NS = 30;     // match chain settling after rise
	localparam int T_OE_NS     = 20;     // output enable low before sampling
	// least times round up to whole cycles
	localparam logic [TMR_W-1:0] SETUP_CYC  = TMR_W'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] LOW_CYC    = TMR_W'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] HIGH_CYC   = TMR_W'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] SETTLE_CYC = TMR_W'((T_SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] OE_CYC     = TMR_W'((T_OE_NS + CLK_NS - 1) / CLK_NS);
	// reset values of pins and results
	localparam logic [RES_W-1:0]  RES_RST  = 16'hFFFF;     // result reads as mismatch
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000; // cleared data

	// bus sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_SETUP   = 6'h02,
		ST_STROBE  = 6'h04,
		ST_RECOVER = 6'h08,
		ST_SETTLE  = 6'h10,
		ST_OE      = 6'h20
	} cch_state_e;

	// one user request
	typedef struct packed {
		logic              write;    // 1 = write cycle, 0 = read cycle
		logic              ctrl;     // 1 = control state or instruction
		logic              compare;  // cycle is a compare: resolve chain
		logic              sel_a;    // assert chip select a
		logic              sel_b;    // assert chip select b
		logic              data_segment_select;      // data segment select level
		logic [AC_W-1:0]   ac;       // address or control state
		logic              vb_n;     // validity on writes, low = valid
		logic [DATA_W-1:0] data;     // write data
	} cch_req_s;

	// one answer
	typedef struct packed {
		logic [DATA_W-1:0] data;     // read data
		logic              vb_n;     // read validity
		logic [RES_W-1:0]  result;   // bank id : active index
		logic              match_n;  // system match flag
		logic              multi_n;  // system multiple hit
		logic              full_n;   // system full flag
	} cch_rsp_s;
endpackage : cch_pkg

// ---- rtl/cch_timer.sv ----
// down-counting phase timer of the bus sequencer
module cch_timer
	import cch_pkg::*;
(
	input  wire logic             clk,      // system clock
	input  wire logic             rst_n,    // async reset, active low
	input  wire logic             load,     // reload the count
	input  wire logic [TMR_W-1:0] load_val, // cycles of the new phase
	output logic                  done      // phase has run out
);
	logic [TMR_W-1:0] cnt_q;  // remaining cycles

	// reload on a phase change, else count down to one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q > TMR_W'(1)) begin
			cnt_q <= cnt_q - TMR_W'(1);
		end
	end

	// last cycle of the phase
	assign done = (cnt_q <= TMR_W'(1));
endmodule : cch_timer

// ---- rtl/cch_host.sv ----
// host controller driving the cam control bus and reading the cascade flags
module cch_host
	import cch_pkg::*;
(
	input  wire logic              CLK_SYS,      // system clock, 125 MHz
	input  wire logic              RESETN,       // async reset, active low
	input  wire logic              REQ_VALID,    // user request present
	output logic                   REQ_READY,    // request taken this cycle
	input  wire cch_req_s          REQ,          // request fields
	output logic                   RSP_VALID,    // answer pulse
	output cch_rsp_s               RSP,          // answer fields
	output logic                   ENABLE_N,     // enable strobe to device
	output logic                   W_N,          // write enable, low = write
	output logic                   SELECT_A_N,   // chip select a
	output logic                   SELECT_B_N,   // chip select b
	output logic                   ADDR_QUALIFIER_N, // low memory, high control
	output logic                   DATA_SEGMENT_SELECT, // segment select
	output logic [AC_W-1:0]        ADDR_CTRL_BUS, // address or control state
	output logic                   OUTPUT_EN_N,  // result output enable
	input  wire logic              VALID_BIT_I_N, // validity line level in
	output logic                   VALID_BIT_O_N, // validity line drive value
	output logic                   VALID_BIT_OE_N, // low while host drives it
	input  wire logic [DATA_W-1:0] DATA_I,       // data bus in
	output logic [DATA_W-1:0]      DATA_O,       // data bus drive value
	output logic                   DATA_OE_N,    // low while host drives data
	input  wire logic [RES_W-1:0]  RESULT_IN,    // bank id : active index
	input  wire logic              MATCH_FLAG_N, // lowest device match flag
	input  wire logic              MULTI_HIT_N,  // wired multiple hit line
	input  wire logic              FULL_FLAG_N   // lowest device full flag
);
	cch_state_e       state_q;     // sequencer state
	cch_state_e       state_d;     // next sequencer state
	cch_req_s         req_q;       // request under way
	cch_rsp_s         rsp_q;       // answer being gathered
	logic             rsp_vld_q;   // answer pulse
	logic             tmr_done;    // current phase ran out
	logic             tmr_load;    // phase changes this cycle
	logic [TMR_W-1:0] tmr_val;     // length of the next phase
	logic             drive_q;     // host owns data and validity lines
	logic             e_n_q;       // strobe register
	logic             oe_n_q;      // output enable register

	// phase timer shared by all timed states
	cch_timer u_timer (
		.clk      (CLK_SYS),
		.rst_n    (RESETN),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	// accept only when idle
	assign REQ_READY = (state_q == ST_IDLE);

	// next state of the bus sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (REQ_VALID) begin
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (tmr_done) begin
					state_d = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (tmr_done) begin
					state_d = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (tmr_done) begin
					// compares wait for the chain, others finish
					state_d = req_q.compare ? ST_SETTLE : ST_IDLE;
				end
			end
			ST_SETTLE: begin
				if (tmr_done) begin
					state_d = ST_OE;
				end
			end
			ST_OE: begin
				if (tmr_done) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// phase length lookup for the timer
	always_comb begin
		tmr_load = (state_d != state_q);
		unique case (state_d)
			ST_SETUP:   tmr_val = SETUP_CYC;
			ST_STROBE:  tmr_val = LOW_CYC;
			ST_RECOVER: tmr_val = HIGH_CYC;
			ST_SETTLE:  tmr_val = SETTLE_CYC;
			ST_OE:      tmr_val = OE_CYC;
			default:    tmr_val = TMR_W'(1); // idle, unused
		endcase
	end

	// state register
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// hold the request for the whole cycle
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			req_q <= '0;
		end else if (REQ_VALID && REQ_READY) begin
			req_q <= REQ;
		end
	end

	// control pins, steady from setup to the end of recovery
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			W_N                 <= 1'b1;
			SELECT_A_N          <= 1'b1;
			SELECT_B_N          <= 1'b1;
			ADDR_QUALIFIER_N    <= 1'b0;
			DATA_SEGMENT_SELECT <= 1'b0;
			ADDR_CTRL_BUS       <= '0;
			VALID_BIT_O_N       <= 1'b1;
			DATA_O              <= DATA_RST;
		end else if (REQ_VALID && REQ_READY) begin
			W_N                 <= ~REQ.write;
			SELECT_A_N          <= ~REQ.sel_a;
			SELECT_B_N          <= ~REQ.sel_b;
			// high carries a control state, or an instruction in software mode
			ADDR_QUALIFIER_N    <= REQ.ctrl;
			DATA_SEGMENT_SELECT <= REQ.data_segment_select;
			ADDR_CTRL_BUS       <= REQ.ac;
			VALID_BIT_O_N       <= REQ.vb_n;
			DATA_O              <= REQ.data;
		end
	end

	// strobe, output enable and bus ownership
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			e_n_q   <= 1'b1;
			oe_n_q  <= 1'b1;
			drive_q <= 1'b0;
		end else begin
			e_n_q   <= (state_d != ST_STROBE);
			// compares enable results only once the match chain has settled,
			// plain cycles enable the accessed address during recovery
			oe_n_q  <= !((state_d == ST_OE)
				|| ((state_d == ST_RECOVER) && !req_q.compare));
			// writes own the data lines from setup through strobe low
			drive_q <= ((state_d == ST_SETUP) || (state_d == ST_STROBE))
				&& (REQ_READY ? REQ.write : req_q.write);
		end
	end

	assign ENABLE_N       = e_n_q;
	assign OUTPUT_EN_N    = oe_n_q;
	assign DATA_OE_N      = ~drive_q;
	assign VALID_BIT_OE_N = ~drive_q;

	// gather answer fields
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rsp_q <= '{data: DATA_RST, vb_n: 1'b1, result: RES_RST,
				match_n: 1'b1, multi_n: 1'b1, full_n: 1'b1};
		end else begin
			// read data and validity taken at the end of strobe low
			if ((state_q == ST_STROBE) && tmr_done && !req_q.write) begin
				rsp_q.data <= DATA_I;
				rsp_q.vb_n <= VALID_BIT_I_N;
			end
			// accessed address flows once the strobe is high again
			if ((state_q == ST_RECOVER) && tmr_done && !req_q.compare) begin
				rsp_q.result <= RESULT_IN;
				rsp_q.full_n <= FULL_FLAG_N;
			end
			// compare result read with output enable low
			if ((state_q == ST_OE) && tmr_done) begin
				rsp_q.result  <= RESULT_IN;
				rsp_q.match_n <= MATCH_FLAG_N;
				rsp_q.multi_n <= MULTI_HIT_N;
				rsp_q.full_n  <= FULL_FLAG_N;
			end
		end
	end

	// answer pulse at the end of the last phase
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rsp_vld_q <= 1'b0;
		end else begin
			rsp_vld_q <= ((state_q == ST_RECOVER) && tmr_done && !req_q.compare)
				|| ((state_q == ST_OE) && tmr_done);
		end
	end

	assign RSP_VALID = rsp_vld_q;
	assign RSP       = rsp_q;
endmodule : cch_host

// ---- verification/cch_host_monitor.sv ----
// port checker for the cascade port host controller
module cch_host_monitor
	import cch_pkg::*;
(
	input wire logic            CLK_SYS,          // clock
	input wire logic            RESETN,           // reset
	input wire logic            REQ_VALID,        // request
	input wire logic            REQ_READY,        // idle
	input wire cch_req_s        REQ,              // request fields
	input wire logic            RSP_VALID,        // answer
	input wire cch_rsp_s        RSP,              // answer fields
	input wire logic            ENABLE_N,         // strobe
	input wire logic            W_N,              // write
	input wire logic            ADDR_QUALIFIER_N, // qualifier
	input wire logic            DATA_SEGMENT_SELECT, // segment select
	input wire logic [AC_W-1:0] ADDR_CTRL_BUS,    // address bus
	input wire logic            OUTPUT_EN_N,      // result enable
	input wire logic            DATA_OE_N,        // data drive
	input wire logic            VALID_BIT_OE_N,   // validity drive
	input wire logic [RES_W-1:0] RESULT_IN,       // result bus
	input wire logic            MATCH_FLAG_N      // system match
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	a_qual_kind: assert property (REQ_VALID && REQ_READY |=>
		ADDR_QUALIFIER_N == $past(REQ.ctrl)) else $error("qualifier wrong");
	a_seg_kind: assert property (REQ_VALID && REQ_READY |=>
		DATA_SEGMENT_SELECT == $past(REQ.data_segment_select)) else $error("segment select wrong");
	a_oe_settled: assert property ($fell(OUTPUT_EN_N) |->
		ENABLE_N && $past(ENABLE_N, 7)) else $error("enable before settle");
	a_oe_window: assert property ($fell(OUTPUT_EN_N) |->
		!OUTPUT_EN_N [*3] ##1 OUTPUT_EN_N) else $error("enable length");
	a_strobe_len: assert property ($fell(ENABLE_N) |->
		!ENABLE_N [*5] ##1 ENABLE_N) else $error("strobe length");
	a_pins_hold: assert property (!ENABLE_N |-> $stable(ADDR_CTRL_BUS) &&
		$stable(W_N) && $stable(ADDR_QUALIFIER_N)) else $error("pins moved");
	a_write_drive: assert property (!ENABLE_N && !W_N |->
		!DATA_OE_N && !VALID_BIT_OE_N) else $error("write not driven");
	a_read_free: assert property (W_N |-> DATA_OE_N)
		else $error("host drives on read");
	a_rsp_flags: assert property (RSP_VALID && $rose(OUTPUT_EN_N) |->
		RSP.match_n == $past(MATCH_FLAG_N) && RSP.result == $past(RESULT_IN))
		else $error("compare answer wrong");
endmodule : cch_host_monitor
bind cch_host cch_host_monitor u_mon (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
	.REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID),
	.RSP(RSP), .ENABLE_N(ENABLE_N), .W_N(W_N), .ADDR_QUALIFIER_N(ADDR_QUALIFIER_N),
	.DATA_SEGMENT_SELECT(DATA_SEGMENT_SELECT),
	.ADDR_CTRL_BUS(ADDR_CTRL_BUS), .OUTPUT_EN_N(OUTPUT_EN_N), .DATA_OE_N(DATA_OE_N),
	.VALID_BIT_OE_N(VALID_BIT_OE_N), .RESULT_IN(RESULT_IN), .MATCH_FLAG_N(MATCH_FLAG_N));

// ---- verification/cch_dev_model.sv ----
// behavioural cam device facing the host
module cch_dev_model
	import cch_pkg::*;
#(
	parameter logic [3:0] BANK = 4'h5 // page address
)(
	input  wire logic              clk,     // idle pattern clock
	input  wire logic              en_n,    // strobe
	input  wire logic              w_n,     // write
	input  wire logic              sa_n,    // select a
	input  wire logic              sb_n,    // select b
	input  wire logic              aq_n,    // qualifier
	input  wire logic [AC_W-1:0]   ac,      // address or state
	input  wire logic              oe_n,    // result enable
	input  wire logic              vb_o_n,  // host validity
	input  wire logic              vb_oe_n, // host drives validity
	input  wire logic [DATA_W-1:0] dq_o,    // host data
	input  wire logic              dq_oe_n, // host drives data
	output logic                   vb_w,    // validity wire
	output logic [DATA_W-1:0]      dq,      // data wire
	output logic [RES_W-1:0]       res,     // result bus
	output logic                   mf_n,    // match flag
	output logic                   mm_n,    // multiple hit
	output logic                   ff_n     // full flag
);
	logic [DATA_W-1:0] mem [16];           // stored words
	logic [15:0]       vld_n = '1;         // low = valid
	logic [RES_W-1:0]  res_q = RES_RST;    // latched result
	logic [DATA_W-1:0] d_q;                // captured data
	logic              w_q, a_q, sel_q, rd_q = 0, tog = 0;
	logic [3:0]        ix;                 // captured index
	int                hits;
	initial {mf_n, mm_n, ff_n} = 3'h7;
	always @(posedge clk) tog <= ~tog;
	// strobe fall captures the cycle
	always @(negedge en_n) begin
		w_q = w_n; a_q = aq_n; ix = ac[3:0]; d_q = dq; sel_q = !sa_n || !sb_n;
		rd_q = w_n && !aq_n && sel_q;
		if (sel_q && !aq_n && !w_n) begin
			mem[ix] = dq; vld_n[ix] = vb_w;
		end
	end
	// strobe rise releases result and flags
	always @(posedge en_n) begin
		rd_q = 0;
		if (!a_q && sel_q) res_q = {BANK, 12'(ix)};
		if (a_q && !w_q) begin
			hits = 0; res_q = '1;
			for (int i = 15; i >= 0; i--) if (sel_q && !vld_n[i] && mem[i] == d_q) begin
				hits++; res_q = {BANK, 12'(i)};
			end
			mf_n = hits == 0; mm_n = hits < 2;
		end
		if (!w_q) ff_n = |vld_n;
	end
	// released lines toggle instead of holding
	assign res  = !oe_n ? res_q : {RES_W{tog}};
	assign dq   = !dq_oe_n ? dq_o : rd_q ? mem[ix] : {DATA_W{tog}};
	assign vb_w = !vb_oe_n ? vb_o_n : rd_q ? vld_n[ix] : tog;
endmodule : cch_dev_model

// ---- verification/test_cch_host.sv ----
// self-checking bench for the cascade port host controller
module test_cch_host
	import cch_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] BANK = 4'h5; // page of the model
	// answer delays after the take edge, plain cycle and compare
	localparam int T_RW  = int'(SETUP_CYC) + int'(LOW_CYC) + int'(HIGH_CYC);
	localparam int T_CMP = T_RW + int'(SETTLE_CYC) + int'(OE_CYC);
	logic clk = 0, rst_n = 0, req_valid = 0, req_ready, rsp_valid, en_n, w_n, sa_n, sb_n;
	logic aq_n, data_segment_select, oe_n, vb_i, vb_o, vb_oe, dq_oe, mf_n, mm_n, ff_n;
	logic [AC_W-1:0] ac;
	logic [DATA_W-1:0] dq_i, dq_o, sm [16];
	logic [RES_W-1:0] res;
	logic [15:0] sv;
	cch_req_s req = '0;
	cch_rsp_s rsp;
	int n_fail = 0, samples_checked = 0, seed = 32'h6a0744f1, lat;
	cch_host uut (.CLK_SYS(clk), .RESETN(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp), .ENABLE_N(en_n), .W_N(w_n),
		.SELECT_A_N(sa_n), .SELECT_B_N(sb_n), .ADDR_QUALIFIER_N(aq_n), .DATA_SEGMENT_SELECT(data_segment_select),
		.ADDR_CTRL_BUS(ac), .OUTPUT_EN_N(oe_n), .VALID_BIT_I_N(vb_i), .VALID_BIT_O_N(vb_o),
		.VALID_BIT_OE_N(vb_oe), .DATA_I(dq_i), .DATA_O(dq_o), .DATA_OE_N(dq_oe),
		.RESULT_IN(res), .MATCH_FLAG_N(mf_n), .MULTI_HIT_N(mm_n), .FULL_FLAG_N(ff_n));
	cch_dev_model #(.BANK(BANK)) u_dev (.clk(clk), .en_n(en_n), .w_n(w_n), .sa_n(sa_n),
		.sb_n(sb_n), .aq_n(aq_n), .ac(ac), .oe_n(oe_n), .vb_o_n(vb_o), .vb_oe_n(vb_oe),
		.dq_o(dq_o), .dq_oe_n(dq_oe), .vb_w(vb_i), .dq(dq_i), .res(res), .mf_n(mf_n),
		.mm_n(mm_n), .ff_n(ff_n));
	initial forever #4 clk = ~clk;
	// compare seen against expected
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// one request, waits for its answer
	task automatic xfer(input logic wr, ctl, input logic [1:0] s, input logic [3:0] a,
		input logic vb, input logic [31:0] d);
		@(posedge clk) #1;
		req = '{wr, ctl, ctl & wr, s[0], s[1], 1'($random(seed)), 13'(a), vb, d};
		req_valid = 1;
		@(posedge clk) #1;
		req_valid = 0;
		lat = 0;
		while (!rsp_valid && lat < 40) begin
			@(posedge clk) #1;
			lat++;
		end
		chk(64'(lat), 64'((ctl & wr) ? T_CMP : T_RW), "answer delay");
	endtask : xfer
	// expected flags and result of a compare
	function automatic logic [17:0] exp_cmp(input logic [31:0] d, input logic sel);
		int h = 0;
		logic [15:0] r = '1;
		for (int i = 15; i >= 0; i--) if (sel && !sv[i] && sm[i] == d) begin
			h++;
			r = {BANK, 12'(i)};
		end
		return {h == 0, h < 2, r};
	endfunction : exp_cmp
	// compare one word and check the answer
	task automatic cmp(input logic [31:0] d, input logic [1:0] s);
		xfer(1, 1, s, 0, 1, d);
		chk(64'({rsp.match_n, rsp.multi_n, rsp.result}), 64'(exp_cmp(d, |s)), "compare");
	endtask : cmp
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	initial begin
		#50000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1;
		for (int i = 0; i < 16; i++) begin
			sm[i] = (i == 9) ? sm[5] : $random(seed);
			sv[i] = (i == 3);
			xfer(1, 0, 2'(1 + i % 2), 4'(i), sv[i], sm[i]);
			chk(64'(rsp.result), 64'({BANK, 12'(i)}), "write address");
		end
		chk(64'(rsp.full_n), 64'(1'b1), "not full");
		$display("test writes done");
		for (int i = 0; i < 16; i++) begin
			xfer(0, 0, 2'h1, 4'(i), 1, 0);
			chk(64'({rsp.vb_n, rsp.data}), 64'({sv[i], sm[i]}), "read back");
			chk(64'(rsp.result), 64'({BANK, 12'(i)}), "read address");
		end
		$display("test reads done");
		cmp(sm[7], 2'h1);
		cmp(sm[5], 2'h2);
		cmp(sm[3], 2'h1);
		cmp(sm[7], 2'h2);
		cmp(sm[7], 2'h0);
		cmp($random(seed), 2'($random(seed)));
		$display("test compares done");
		sv[3] = 0;
		xfer(1, 0, 2'h1, 4'h3, 0, sm[3]);
		chk(64'(rsp.full_n), 64'(1'b0), "full");
		cmp(sm[3], 2'h1);
		$display("test full done");
		finish_test();
	end
endmodule : test_cch_host
